// File: rtl/srm_pkg.sv
/*
 Constants for the sensor register map block: addresses, lock/CRC field
 layout, reset values and the writable-array CRC polynomial.
 Assumes an 8-bit register address space reached by a serial front end.
*/
package srm_pkg;
	localparam logic [7:0] ADDR_DEVICE_LOCK_WR = 8'h0010;
	localparam logic [7:0] ADDR_INIT_CTRL = 8'h0011;
	localparam logic [7:0] ADDR_CFG_FIRST = 8'h0012;
	localparam logic [7:0] ADDR_CFG_LAST = 8'h0017;
	localparam logic [7:0] ADDR_STATUS = 8'h0018;
	localparam logic [7:0] ADDR_OTP_WR_EN = 8'h0019;
	localparam logic [7:0] ADDR_USER_FIRST = 8'h0040;
	localparam logic [7:0] ADDR_USER_LAST = 8'h005e;
	localparam logic [7:0] ADDR_USER_GAP = 8'h004f;
	localparam logic [7:0] ADDR_USER_B2_LOCK_CRC = 8'h005f;
	localparam logic [7:0] ADDR_F_A_LOCK_CRC = 8'h00af;
	localparam logic [7:0] ADDR_F_B_LOCK_CRC = 8'h00bf;
	localparam logic [7:0] ADDR_WAFER_X = 8'h00cc;
	localparam logic [7:0] ADDR_WAFER_Y = 8'h00cd;
	localparam logic [7:0] ADDR_F_C_LOCK_CRC = 8'h00cf;
	localparam logic [7:0] ADDR_WAFER_LOT_LOW = 8'h00d0;
	localparam logic [7:0] ADDR_WAFER_LOT_HIGH = 8'h00d1;
	localparam logic [7:0] ADDR_F_D_LOCK_CRC = 8'h00df;
	localparam logic [7:0] ADDR_F_E_LOCK_CRC = 8'h00ef;
	localparam logic [7:0] ADDR_F_F_LOCK_CRC = 8'h00ff;
	localparam int USER_WORDS = 31;
	localparam int CFG_WORDS = 6;
	localparam int LOCK_BIT = 7;
	localparam int BLKID_HI = 6;
	localparam int BLKID_LO = 4;
	localparam int CRC_HI = 3;
	localparam int CRC_LO = 0;
	localparam logic [2:0] USER_B2_BLOCK_ID = 3'h0;
	localparam logic [7:0] F_A_LOCK_CRC_RST = 8'h0090;
	localparam logic [7:0] F_B_LOCK_CRC_RST = 8'h00a0;
	localparam logic [7:0] F_C_LOCK_CRC_RST = 8'h00b0;
	localparam logic [7:0] F_D_LOCK_CRC_RST = 8'h00d0;
	localparam logic [7:0] F_E_LOCK_CRC_RST = 8'h0000;
	localparam logic [7:0] F_F_LOCK_CRC_RST = 8'h0000;
	localparam logic [7:0] USER_B2_LOCK_CRC_RST = 8'h0000;
	localparam logic [7:0] WAFER_X_DEF = 8'h0000;
	localparam logic [7:0] WAFER_Y_DEF = 8'h0000;
	localparam logic [7:0] WAFER_LOT_LOW_DEF = 8'h0000;
	localparam logic [7:0] WAFER_LOT_HIGH_DEF = 8'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h0000;
	localparam logic [3:0] CRC_SEED = 4'h0;
	localparam logic [3:0] CRC_POLY = 4'h9;
	localparam logic [7:0] OTP_BURN_USER = 8'h00a5;
	localparam int STAT_CRC_ERR = 0;
	localparam int STAT_INIT = 1;
	localparam int STAT_BURN_REFUSED = 2;
	localparam int STAT_LOCKED = 3;
	localparam int TOTAL_WORDS = USER_WORDS + CFG_WORDS;
	localparam logic [5:0] LAST_IDX = 6'(TOTAL_WORDS - 1);
	typedef enum logic [1:0] {
		SRM_IDLE = 2'b00,
		SRM_SCAN = 2'b01,
		SRM_DONE = 2'b10
	} srm_scan_e;
endpackage

// File: rtl/srm_regmap.sv
/*
 Register map of the pressure sensor user array with lock/CRC registers
 and a continuous CRC check of the writable array.
 Assumes a serial front end (SPI or I2C) that presents one register
 command per req pulse on clk and takes the answer on rsp_valid.
*/
// What this block does
// - User OTP words are readable and writable only while init flag is clear.
// - User OTP words are covered by the user block CRC.
// - Wafer lot number is two read-only bytes, low then high address.
// - Burning a block via OTP write enable also programs its lock/CRC.
// - Lock/CRC register: lock bit 7, block id 6:4, CRC 3:0.
// - Reads of reserved registers or bits answer validly; bits are zero.
// - Writes to reserved registers or bits execute and answer validly.
// - Reads outside the array answer validly with zero data.
// - Writes outside the array change nothing and answer with zero.
// - Writes to read-only registers are dropped, answering present contents.
// - After init flag sets, CRC over the user and configuration words runs continuously.
// - CRC polynomial x^4+x^3+1 from an all-zero seed.
`timescale 1ns/1ps
module srm_regmap
	import srm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register command
	input wire logic req,
	input wire logic req_write,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	// Register answer
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	// Status
	output logic init_complete_flag,
	output logic crc_error
);
	logic rst_sync1_r, rst_sync2_r;
	logic [7:0] user_word_r [USER_WORDS];
	logic [7:0] cfg_r [CFG_WORDS];
	logic [7:0] device_lock_write_reg_r;
	logic init_r;
	logic [7:0] user_b2_lock_crc_r;
	logic burn_refused_r;
	logic [3:0] crc_acc_r, crc_ref_r;
	logic ref_valid_r;
	logic crc_err_r;
	logic [5:0] scan_idx_r;
	srm_scan_e scan_r;
	logic rsp_valid_r;
	logic [7:0] rsp_rdata_r;
	logic [3:0] user_crc;
	logic [3:0] step_crc;
	logic [7:0] scan_byte;
	logic [7:0] rd_data;
	logic user_hit, cfg_hit, known_ro;
	logic [4:0] user_idx;
	logic [2:0] cfg_idx;
	logic wr_ok;
	logic burn_req;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
		end else begin
			rst_sync1_r <= 1'b1;
			rst_sync2_r <= rst_sync1_r;
		end
	end

	// CRC-4 byte step, MSB first
	function automatic logic [3:0] crc4_byte(input logic [3:0] c,
		input logic [7:0] d);
		logic [3:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[3] ^ d[i]) begin
				r = {r[2:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[2:0], 1'b0};
			end
		end
		return r;
	endfunction

	// User block CRC over all user words, from zero seed
	always_comb begin
		user_crc = CRC_SEED;
		for (int i = 0; i < USER_WORDS; i++) begin
			user_crc = crc4_byte(user_crc, user_word_r[i]);
		end
	end

	// Address decode
	always_comb begin
		user_hit = (req_addr >= ADDR_USER_FIRST) &&
			(req_addr <= ADDR_USER_LAST) && (req_addr != ADDR_USER_GAP);
		if (req_addr > ADDR_USER_GAP) begin
			user_idx = 5'(req_addr - ADDR_USER_FIRST - 8'h0001);
		end else begin
			user_idx = 5'(req_addr - ADDR_USER_FIRST);
		end
		cfg_hit = (req_addr >= ADDR_CFG_FIRST) && (req_addr <= ADDR_CFG_LAST);
		cfg_idx = 3'(req_addr - ADDR_CFG_FIRST);
	end

	// Read multiplexer; reserved bits of status read as zero
	always_comb begin
		rd_data = BYTE_ZERO;
		known_ro = 1'b1;
		if (user_hit) begin
			known_ro = 1'b0;
			if (!init_r) begin
				rd_data = user_word_r[user_idx];
			end
		end else if (cfg_hit) begin
			known_ro = 1'b0;
			rd_data = cfg_r[cfg_idx];
		end else begin
			unique case (req_addr)
				ADDR_DEVICE_LOCK_WR: begin
					known_ro = 1'b0;
					rd_data = device_lock_write_reg_r;
				end
				ADDR_INIT_CTRL: begin
					known_ro = 1'b0;
					rd_data = {7'h00, init_r};
				end
				ADDR_OTP_WR_EN: known_ro = 1'b0;
				ADDR_STATUS: rd_data = {4'h0,
					user_b2_lock_crc_r[LOCK_BIT], burn_refused_r,
					init_r, crc_err_r};
				ADDR_USER_B2_LOCK_CRC: rd_data = user_b2_lock_crc_r;
				ADDR_F_A_LOCK_CRC: rd_data = F_A_LOCK_CRC_RST;
				ADDR_F_B_LOCK_CRC: rd_data = F_B_LOCK_CRC_RST;
				ADDR_F_C_LOCK_CRC: rd_data = F_C_LOCK_CRC_RST;
				ADDR_F_D_LOCK_CRC: rd_data = F_D_LOCK_CRC_RST;
				ADDR_F_E_LOCK_CRC: rd_data = F_E_LOCK_CRC_RST;
				ADDR_F_F_LOCK_CRC: rd_data = F_F_LOCK_CRC_RST;
				ADDR_WAFER_X: rd_data = WAFER_X_DEF;
				ADDR_WAFER_Y: rd_data = WAFER_Y_DEF;
				ADDR_WAFER_LOT_LOW: rd_data = WAFER_LOT_LOW_DEF;
				ADDR_WAFER_LOT_HIGH: rd_data = WAFER_LOT_HIGH_DEF;
				default: known_ro = 1'b0;
			endcase
		end
	end

	assign wr_ok = req && req_write && !known_ro;
	assign burn_req = wr_ok && req_addr == ADDR_OTP_WR_EN &&
		req_wdata == OTP_BURN_USER;

	// Answer valid: one cycle after each command
	always_ff @(posedge clk or negedge rst_sync2_r) begin
		if (!rst_sync2_r) begin
			rsp_valid_r <= 1'b0;
		end else begin
			rsp_valid_r <= req;
		end
	end

	// Answer data: zero between answers
	always_ff @(posedge clk or negedge rst_sync2_r) begin
		if (!rst_sync2_r) begin
			rsp_rdata_r <= BYTE_ZERO;
		end else begin
			rsp_rdata_r <= req ? rd_data : BYTE_ZERO;
		end
	end

	// User OTP words, one register per entry; the last entry has no
	// address and stays zero, so it only pads the user block CRC and the array scan
	for (genvar g = 0; g < USER_WORDS; g++) begin : g_user
		always_ff @(posedge clk or negedge rst_sync2_r) begin
			if (!rst_sync2_r) begin
				user_word_r[g] <= BYTE_ZERO;
			end else if (wr_ok && user_hit && user_idx == 5'(g) &&
				!init_r && !user_b2_lock_crc_r[LOCK_BIT]) begin
				user_word_r[g] <= req_wdata;
			end
		end
	end

	// Configuration words, writable and covered by the array CRC
	for (genvar g = 0; g < CFG_WORDS; g++) begin : g_cfg
		always_ff @(posedge clk or negedge rst_sync2_r) begin
			if (!rst_sync2_r) begin
				cfg_r[g] <= BYTE_ZERO;
			end else if (wr_ok && cfg_hit && cfg_idx == 3'(g)) begin
				cfg_r[g] <= req_wdata;
			end
		end
	end

	// Device lock write register, kept out of the array CRC
	always_ff @(posedge clk or negedge rst_sync2_r) begin
		if (!rst_sync2_r) begin
			device_lock_write_reg_r <= BYTE_ZERO;
		end else if (wr_ok && req_addr == ADDR_DEVICE_LOCK_WR) begin
			device_lock_write_reg_r <= req_wdata;
		end
	end

	// Init flag is sticky until reset
	always_ff @(posedge clk or negedge rst_sync2_r) begin
		if (!rst_sync2_r) begin
			init_r <= 1'b0;
		end else if (wr_ok && req_addr == ADDR_INIT_CTRL &&
			req_wdata[0]) begin
			init_r <= 1'b1;
		end
	end

	// Burn of the user block programs its lock/CRC register once
	always_ff @(posedge clk or negedge rst_sync2_r) begin
		if (!rst_sync2_r) begin
			user_b2_lock_crc_r <= USER_B2_LOCK_CRC_RST;
		end else if (burn_req && !init_r &&
			!user_b2_lock_crc_r[LOCK_BIT]) begin
			user_b2_lock_crc_r[LOCK_BIT] <= 1'b1;
			user_b2_lock_crc_r[BLKID_HI:BLKID_LO] <= USER_B2_BLOCK_ID;
			user_b2_lock_crc_r[CRC_HI:CRC_LO] <= user_crc;
		end
	end

	// Refused burn: block already locked or init already complete
	always_ff @(posedge clk or negedge rst_sync2_r) begin
		if (!rst_sync2_r) begin
			burn_refused_r <= 1'b0;
		end else if (burn_req &&
			(user_b2_lock_crc_r[LOCK_BIT] || init_r)) begin
			burn_refused_r <= 1'b1;
		end
	end

	// Scan byte for the writable-array CRC
	always_comb begin
		if (scan_idx_r < 6'(USER_WORDS)) begin
			scan_byte = user_word_r[5'(scan_idx_r)];
		end else begin
			scan_byte = cfg_r[3'(scan_idx_r - 6'(USER_WORDS))];
		end
		step_crc = crc4_byte(crc_acc_r, scan_byte);
	end

	// Continuous CRC scan over writable array, device lock excluded
	always_ff @(posedge clk or negedge rst_sync2_r) begin
		if (!rst_sync2_r) begin
			scan_r <= SRM_IDLE;
			scan_idx_r <= 6'h00;
			crc_acc_r <= CRC_SEED;
			crc_ref_r <= CRC_SEED;
			ref_valid_r <= 1'b0;
		end else begin
			unique case (scan_r)
				SRM_IDLE: begin
					if (init_r) begin
						scan_r <= SRM_SCAN;
					end
					scan_idx_r <= 6'h00;
					crc_acc_r <= CRC_SEED;
				end
				SRM_SCAN: begin
					crc_acc_r <= step_crc;
					if (scan_idx_r == LAST_IDX) begin
						scan_r <= SRM_DONE;
					end else begin
						scan_idx_r <= scan_idx_r + 6'h01;
					end
				end
				SRM_DONE: begin
					if (!ref_valid_r) begin
						crc_ref_r <= crc_acc_r;
						ref_valid_r <= 1'b1;
					end
					scan_idx_r <= 6'h00;
					crc_acc_r <= CRC_SEED;
					scan_r <= SRM_SCAN;
				end
				default: scan_r <= SRM_IDLE;
			endcase
		end
	end

	// Sticky CRC mismatch flag
	always_ff @(posedge clk or negedge rst_sync2_r) begin
		if (!rst_sync2_r) begin
			crc_err_r <= 1'b0;
		end else if (scan_r == SRM_DONE && ref_valid_r &&
			crc_acc_r != crc_ref_r) begin
			crc_err_r <= 1'b1;
		end
	end

	assign rsp_valid = rsp_valid_r;
	assign rsp_rdata = rsp_rdata_r;
	assign init_complete_flag = init_r;
	assign crc_error = crc_err_r;
endmodule

// File: verification/srm_regmap_assertions.sv
/* Port checker for srm_regmap: answer timing, fixed contents, flags.
 Assumes it is bound to srm_regmap and no request comes in reset. */
`timescale 1ns/1ps
module srm_regmap_chk
	import srm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Command
	input wire logic req,
	input wire logic req_write,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	// Answer and status
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_rdata,
	input wire logic init_complete_flag,
	input wire logic crc_error
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_ans; req |=> rsp_valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_quiet; !req |=> !rsp_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("extra answer");
	property p_idle; !rsp_valid |-> rsp_rdata == BYTE_ZERO; endproperty
	a_idle: assert property (p_idle) else $error("idle data");
	property p_out;
		req && req_addr < ADDR_DEVICE_LOCK_WR |=> rsp_rdata == BYTE_ZERO;
	endproperty
	a_out: assert property (p_out) else $error("unmapped data");
	property p_ro;
		req && req_addr == ADDR_F_B_LOCK_CRC |=> rsp_rdata == F_B_LOCK_CRC_RST;
	endproperty
	a_ro: assert property (p_ro) else $error("lock word changed");
	property p_lot;
		req && req_addr == ADDR_WAFER_LOT_HIGH
			|=> rsp_rdata == WAFER_LOT_HIGH_DEF;
	endproperty
	a_lot: assert property (p_lot) else $error("lot byte");
	property p_user;
		init_complete_flag && req && !req_write && req_addr == ADDR_USER_FIRST
			|=> rsp_rdata == BYTE_ZERO;
	endproperty
	a_user: assert property (p_user) else $error("user word open");
	property p_init; $rose(init_complete_flag) |=> init_complete_flag[*8];
	endproperty
	a_init: assert property (p_init) else $error("init flag fell");
	property p_crc; !init_complete_flag |-> !crc_error; endproperty
	a_crc: assert property (p_crc) else $error("early crc error");
	property p_stick; crc_error |=> $stable(crc_error); endproperty
	a_stick: assert property (p_stick) else $error("crc error fell");
endmodule
bind srm_regmap srm_regmap_chk u_srm_regmap_chk (.clk(clk), .rstn(rstn),
	.req(req), .req_write(req_write), .req_addr(req_addr),
	.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
	.init_complete_flag(init_complete_flag), .crc_error(crc_error));

// File: verification/srm_host.sv
/* Host model: issues one register command per call and takes the answer.
 Assumes the bench clock; drives at falling edges only. */
`timescale 1ns/1ps
module srm_host (
	// Clock
	input wire logic clk,
	// Command out
	output logic req,
	output logic req_write,
	output logic [7:0] req_addr,
	output logic [7:0] req_wdata,
	// Answer in
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_rdata
);
	initial begin
		req = 1'b0;
		req_write = 1'b1;
		req_addr = 8'hff;
		req_wdata = 8'hff;
	end
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic v, output logic [7:0] q);
		@(negedge clk);
		req = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge clk);
		v = rsp_valid;
		q = rsp_rdata;
		req = 1'b0;
		// Qualifiers take the inverse of their last value once released
		req_write = ~w;
		req_addr = ~a;
		req_wdata = ~d;
	endtask
endmodule

// File: verification/tb_srm_regmap.sv
/* Self-checking bench for srm_regmap through the host model.
 Assumes the package constants and answer one cycle after a command. */
`timescale 1ns/1ps
module tb_srm_regmap;
	import srm_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;}
		srm_row_s;
	logic clk, rstn, req, req_write, rsp_valid, init_complete_flag, crc_error;
	logic [7:0] req_addr, req_wdata, rsp_rdata, q;
	logic [7:0] uw [0:30];
	logic v;
	logic [3:0] crc;
	int err_count, samples_checked, k;
	srm_row_s rows [0:15] = '{
		'{0, ADDR_WAFER_LOT_LOW, 0, WAFER_LOT_LOW_DEF},
		'{0, ADDR_WAFER_LOT_HIGH, 0, WAFER_LOT_HIGH_DEF},
		'{1, ADDR_WAFER_LOT_HIGH, 8'hff, WAFER_LOT_HIGH_DEF},
		'{0, ADDR_WAFER_X, 0, WAFER_X_DEF}, '{1, ADDR_WAFER_Y, 8'h5a, WAFER_Y_DEF},
		'{0, ADDR_USER_B2_LOCK_CRC, 0, USER_B2_LOCK_CRC_RST},
		'{0, ADDR_F_A_LOCK_CRC, 0, F_A_LOCK_CRC_RST},
		'{1, ADDR_F_B_LOCK_CRC, 8'hff, F_B_LOCK_CRC_RST},
		'{0, ADDR_F_C_LOCK_CRC, 0, F_C_LOCK_CRC_RST},
		'{0, ADDR_F_D_LOCK_CRC, 0, F_D_LOCK_CRC_RST},
		'{0, ADDR_F_E_LOCK_CRC, 0, F_E_LOCK_CRC_RST},
		'{0, ADDR_F_F_LOCK_CRC, 0, F_F_LOCK_CRC_RST},
		'{1, 8'h05, 8'haa, 0}, '{0, 8'h05, 0, 0}, '{0, ADDR_USER_GAP, 0, 0},
		'{1, 8'h41, 8'hc3, 8'h0c}};
	srm_regmap u_srm_regmap (.clk(clk), .rstn(rstn), .req(req),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.init_complete_flag(init_complete_flag), .crc_error(crc_error));
	srm_host u_srm_host (.clk(clk), .req(req), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
		u_srm_host.xfer(w, a, d, v, q);
		chk({7'h00, v}, 8'h01);
	endtask
	task automatic results();
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		err_count++;
		results();
	end
	initial begin
		rstn = 1'b0;
		repeat (8) @(negedge clk);
		chk({rsp_valid, init_complete_flag, crc_error}, 8'h00);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 31; i++) begin
			uw[i] = (i == 15) ? 8'h00 : 8'(i * 11 + 1);
			if (i != 15)
				cmd(1, ADDR_USER_FIRST + 8'(i), uw[i]);
		end
		cmd(0, ADDR_USER_FIRST, 0);
		chk(q, uw[0]);
		foreach (rows[i]) begin
			cmd(rows[i].w, rows[i].a, rows[i].d);
			chk(q, rows[i].e);
		end
		uw[1] = 8'hc3;
		cmd(0, 8'h41, 0);
		chk(q, 8'hc3);
		// Word order: 0x40..0x4E, 0x50..0x5E, then the zero pad word
		crc = CRC_SEED;
		for (int i = 0; i < 31; i++) begin
			k = (i < 15) ? i : ((i == 30) ? 15 : i + 1);
			for (int b = 7; b >= 0; b--)
				crc = {crc[2:0], 1'b0} ^ ((crc[3] ^ uw[k][b]) ? CRC_POLY : 4'h0);
		end
		cmd(1, ADDR_OTP_WR_EN, OTP_BURN_USER);
		q = 8'h00;
		for (k = 0; k < 100 && q[LOCK_BIT] !== 1'b1; k++)
			cmd(0, ADDR_USER_B2_LOCK_CRC, 0);
		chk(q, {1'b1, USER_B2_BLOCK_ID, crc});
		cmd(1, ADDR_USER_FIRST, 8'h77);
		cmd(0, ADDR_USER_FIRST, 0);
		chk(q, uw[0]);
		cmd(1, ADDR_OTP_WR_EN, OTP_BURN_USER);
		cmd(0, ADDR_STATUS, 0);
		chk({7'h00, q[STAT_BURN_REFUSED]}, 8'h01);
		cmd(1, ADDR_INIT_CTRL, 8'h01);
		for (k = 0; k < 10 && init_complete_flag !== 1'b1; k++)
			@(negedge clk);
		cmd(0, ADDR_USER_FIRST, 0);
		chk(q, 8'h00);
		chk({7'h00, init_complete_flag}, 8'h01);
		repeat (120) @(negedge clk);
		chk({7'h00, crc_error}, 8'h00);
		cmd(1, ADDR_DEVICE_LOCK_WR, 8'h3c);
		repeat (100) @(negedge clk);
		chk({7'h00, crc_error}, 8'h00);
		cmd(0, ADDR_DEVICE_LOCK_WR, 0);
		chk(q, 8'h3c);
		cmd(0, ADDR_CFG_FIRST, 0);
		cmd(1, ADDR_CFG_FIRST, ~q);
		for (k = 0; k < 300 && crc_error !== 1'b1; k++)
			@(negedge clk);
		chk({7'h00, crc_error}, 8'h01);
		cmd(0, ADDR_STATUS, 0);
		chk(q, 8'h0f);
		rstn = 1'b0;
		#1;
		chk({init_complete_flag, crc_error}, 8'h00);
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		cmd(0, ADDR_CFG_FIRST, 0);
		chk(q, 8'h00);
		results();
	end
endmodule
